// File: verilog/uart_regs_map.vh
// Register offsets, field positions and reset values of the serial channel registers
`ifndef UART_REGS_MAP_VH
`define UART_REGS_MAP_VH

// ****************************************
// Register offsets
// ****************************************
`define UART_CLK_CTRL_OFS   16'h4380
`define UART_FRAME_MODE_OFS 16'h4382
`define UART_BAUD_RATE_OFS  16'h4384
`define UART_CONTROL_OFS    16'h4386
`define UART_TX_DATA_OFS    16'h4388
`define UART_RX_DATA_OFS    16'h438A
`define UART_STATUS_OFS     16'h438C
`define UART_INT_EN_OFS     16'h438E

// ****************************************
// Writable masks
// ****************************************
`define UART_CLK_CTRL_MASK   16'h0133
`define UART_FRAME_MODE_MASK 16'h077F
`define UART_BAUD_RATE_MASK  16'h0FFF
`define UART_CONTROL_MASK    16'h0003
`define UART_INT_EN_MASK     16'h007F

// ****************************************
// Field positions
// ****************************************
`define UART_CTL_MODEN_BIT  0
`define UART_CTL_SFTRST_BIT 1
`define UART_ST_TBE_BIT     0
`define UART_ST_RB1_BIT     1
`define UART_ST_RB2_BIT     2
`define UART_ST_OE_BIT      3
`define UART_ST_PE_BIT      4
`define UART_ST_FE_BIT      5
`define UART_ST_TEND_BIT    6
`define UART_ST_TBSY_BIT    8
`define UART_ST_RBSY_BIT    9

// ****************************************
// Reset values and receive buffer depth
// ****************************************
`define UART_REG_RESET   16'h0000
`define UART_FLAGS_RESET 7'h01
`define UART_RX_DEPTH    2

`endif

// File: verilog/uart_register_interface.v
// Register interface of one asynchronous serial channel
`timescale 1ns/1ps
`include "uart_regs_map.vh"

// Overview of operation
// RL1 - Transmission-end and overrun flags clear only when software writes one to them or on a soft reset.
// RL2 - Framing and parity flags clear on write-one or on any receive data read.
// RL3 - One-byte and two-bytes received flags are read-only, cleared by receive data read.
// RL4 - Transmit-buffer-empty resets to one, read-only, cleared by transmit data write.
// RL5 - Interrupt request is high while any flag and its same-position enable are set.
module uart_register_interface (
  // Clock and reset
  input  wire        MCLK,
  input  wire        RESET_N,
  // Register port
  input  wire [15:0] ADDR,
  input  wire [15:0] WDATA,
  input  wire        WR,
  input  wire        RD,
  output reg  [15:0] RDATA,
  // Interrupt
  output reg         IRQ,
  // Configuration to the serial engine
  output reg  [1:0]  CLK_SRC,
  output reg  [1:0]  CLK_DIV,
  output reg         DBG_RUN,
  output reg  [10:0] FRAME_MODE,
  output reg  [3:0]  BAUD_FINE,
  output reg  [7:0]  BAUD_COUNT,
  output reg         MOD_EN,
  output reg         SOFT_RST,
  // Transmit side of the engine
  output reg  [7:0]  TX_DATA,
  output reg         TX_LOAD,
  input  wire        TX_TAKEN,
  input  wire        TX_END_EVT,
  input  wire        TX_BUSY,
  // Receive side of the engine
  input  wire        RX_PUSH,
  input  wire [7:0]  RX_BYTE,
  input  wire        RX_FERR,
  input  wire        RX_PERR,
  input  wire        RX_BUSY
);

  // ****************************************
  // Declarations
  // ****************************************
  reg  [15:0] clk_ctrl_reg;
  reg  [15:0] frame_mode_reg;
  reg  [15:0] baud_rate_reg;
  reg  [15:0] control_reg;
  reg  [7:0]  tx_data_reg;
  reg  [15:0] int_en_reg;
  reg  [15:0] int_en_next;
  reg  [6:0]  flags_reg;
  reg  [6:0]  flags_next;
  reg  [7:0]  rx_mem [0:`UART_RX_DEPTH-1];
  reg         rx_head_reg;
  reg  [1:0]  rx_count_reg;
  reg  [1:0]  rx_count_next;
  reg  [15:0] rdata_next;
  reg  [6:0]  set_vec;
  reg  [6:0]  clr_vec;
  wire        srst;
  wire        wr_clk;
  wire        wr_mode;
  wire        wr_baud;
  wire        wr_ctl;
  wire        wr_txd;
  wire        wr_st;
  wire        wr_ie;
  wire        rd_rxd;
  wire        rx_full;
  wire        rx_pop;
  wire        push_ok;
  wire        wr_idx;

  // ****************************************
  // Address decode
  // ****************************************
  assign wr_clk  = WR && (ADDR == `UART_CLK_CTRL_OFS);
  assign wr_mode = WR && (ADDR == `UART_FRAME_MODE_OFS);
  assign wr_baud = WR && (ADDR == `UART_BAUD_RATE_OFS);
  assign wr_ctl  = WR && (ADDR == `UART_CONTROL_OFS);
  assign wr_txd  = WR && (ADDR == `UART_TX_DATA_OFS);
  assign wr_st   = WR && (ADDR == `UART_STATUS_OFS);
  assign wr_ie   = WR && (ADDR == `UART_INT_EN_OFS);
  assign rd_rxd  = RD && (ADDR == `UART_RX_DATA_OFS);

  // Soft reset is a one-cycle pulse so software need not clear it
  assign srst = control_reg[`UART_CTL_SFTRST_BIT];

  // ****************************************
  // Receive buffer, two entries
  // ****************************************
  assign rx_full = (rx_count_reg == 2'd2);
  assign rx_pop  = rd_rxd && (rx_count_reg != 2'd0) && !srst;
  // A pop in the same cycle frees a slot, so a full buffer still accepts
  assign push_ok = RX_PUSH && (!rx_full || rx_pop) && !srst;
  assign wr_idx  = rx_head_reg ^ rx_count_reg[0];

  always @* begin
    rx_count_next = rx_count_reg;
    if (srst) begin
      rx_count_next = 2'd0;
    end else if (push_ok && !rx_pop) begin
      rx_count_next = rx_count_reg + 2'd1;
    end else if (rx_pop && !push_ok) begin
      rx_count_next = rx_count_reg - 2'd1;
    end
  end

  always @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rx_head_reg  <= 1'b0;
      rx_count_reg <= 2'd0;
      rx_mem[0]    <= 8'h00;
      rx_mem[1]    <= 8'h00;
    end else begin
      rx_count_reg <= rx_count_next;
      if (srst) begin
        rx_head_reg <= 1'b0;
      end else if (rx_pop) begin
        rx_head_reg <= ~rx_head_reg;
      end
      if (push_ok) begin
        rx_mem[wr_idx] <= RX_BYTE;
      end
    end
  end

  // ****************************************
  // Status flags
  // ****************************************
  // Hardware set wins over a write-one or read clear in the same cycle; a soft reset overrides both
  always @* begin
    set_vec = 7'h00;
    clr_vec = 7'h00;
    set_vec[`UART_ST_TEND_BIT] = TX_END_EVT;
    set_vec[`UART_ST_FE_BIT]   = push_ok && RX_FERR;
    set_vec[`UART_ST_PE_BIT]   = push_ok && RX_PERR;
    set_vec[`UART_ST_OE_BIT]   = RX_PUSH && !push_ok && !srst;
    set_vec[`UART_ST_TBE_BIT]  = TX_TAKEN;
    if (wr_st) begin
      clr_vec[`UART_ST_TEND_BIT] = WDATA[`UART_ST_TEND_BIT]; // RL1
      clr_vec[`UART_ST_OE_BIT]   = WDATA[`UART_ST_OE_BIT]; // RL1
      clr_vec[`UART_ST_FE_BIT]   = WDATA[`UART_ST_FE_BIT]; // RL2
      clr_vec[`UART_ST_PE_BIT]   = WDATA[`UART_ST_PE_BIT]; // RL2
    end
    if (rd_rxd) begin
      clr_vec[`UART_ST_FE_BIT] = 1'b1; // RL2
      clr_vec[`UART_ST_PE_BIT] = 1'b1; // RL2
    end
    clr_vec[`UART_ST_TBE_BIT] = wr_txd; // RL4
    flags_next = (flags_reg & ~clr_vec) | set_vec;
    // Receive levels follow the buffer fill; a read pops one entry
    flags_next[`UART_ST_RB1_BIT] = (rx_count_next != 2'd0); // RL3
    flags_next[`UART_ST_RB2_BIT] = (rx_count_next == 2'd2); // RL3
    if (srst) begin
      flags_next = `UART_FLAGS_RESET; // RL4
    end
  end

  always @* begin
    int_en_next = int_en_reg;
    if (wr_ie) begin
      int_en_next = WDATA & `UART_INT_EN_MASK;
    end
  end

  // ****************************************
  // Register storage
  // ****************************************
  always @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      clk_ctrl_reg   <= `UART_REG_RESET;
      frame_mode_reg <= `UART_REG_RESET;
      baud_rate_reg  <= `UART_REG_RESET;
      control_reg    <= `UART_REG_RESET;
      tx_data_reg    <= 8'h00;
      int_en_reg     <= `UART_REG_RESET;
      flags_reg      <= `UART_FLAGS_RESET; // RL4
    end else begin
      if (wr_clk) begin
        clk_ctrl_reg <= WDATA & `UART_CLK_CTRL_MASK;
      end
      if (wr_mode) begin
        frame_mode_reg <= WDATA & `UART_FRAME_MODE_MASK;
      end
      if (wr_baud) begin
        baud_rate_reg <= WDATA & `UART_BAUD_RATE_MASK;
      end
      if (wr_ctl) begin
        control_reg <= WDATA & `UART_CONTROL_MASK;
      end else begin
        control_reg[`UART_CTL_SFTRST_BIT] <= 1'b0;
      end
      if (wr_txd) begin
        tx_data_reg <= WDATA[7:0];
      end
      int_en_reg <= int_en_next;
      flags_reg  <= flags_next;
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  always @* begin
    rdata_next = 16'h0000;
    if (RD) begin
      case (ADDR)
        `UART_CLK_CTRL_OFS:   rdata_next = clk_ctrl_reg;
        `UART_FRAME_MODE_OFS: rdata_next = frame_mode_reg;
        `UART_BAUD_RATE_OFS:  rdata_next = baud_rate_reg;
        `UART_CONTROL_OFS:    rdata_next = control_reg;
        `UART_TX_DATA_OFS:    rdata_next = {8'h00, tx_data_reg};
        `UART_RX_DATA_OFS:    rdata_next = {8'h00, rx_mem[rx_head_reg]};
        `UART_STATUS_OFS: begin
          rdata_next[6:0] = flags_reg;
          rdata_next[`UART_ST_TBSY_BIT] = TX_BUSY;
          rdata_next[`UART_ST_RBSY_BIT] = RX_BUSY;
        end
        `UART_INT_EN_OFS:     rdata_next = int_en_reg;
        default:              rdata_next = 16'h0000;
      endcase
    end
  end

  // ****************************************
  // Registered outputs
  // ****************************************
  always @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      RDATA      <= 16'h0000;
      IRQ        <= 1'b0;
      CLK_SRC    <= 2'b00;
      CLK_DIV    <= 2'b00;
      DBG_RUN    <= 1'b0;
      FRAME_MODE <= 11'h000;
      BAUD_FINE  <= 4'h0;
      BAUD_COUNT <= 8'h00;
      MOD_EN     <= 1'b0;
      SOFT_RST   <= 1'b0;
      TX_DATA    <= 8'h00;
      TX_LOAD    <= 1'b0;
    end else begin
      RDATA      <= rdata_next;
      // Built from next values so the request tracks the flags without lag
      IRQ        <= |(flags_next & int_en_next[6:0]); // RL5
      CLK_SRC    <= clk_ctrl_reg[1:0];
      CLK_DIV    <= clk_ctrl_reg[5:4];
      DBG_RUN    <= clk_ctrl_reg[8];
      FRAME_MODE <= frame_mode_reg[10:0];
      BAUD_FINE  <= baud_rate_reg[11:8];
      BAUD_COUNT <= baud_rate_reg[7:0];
      MOD_EN     <= control_reg[`UART_CTL_MODEN_BIT];
      SOFT_RST   <= srst;
      TX_DATA    <= wr_txd ? WDATA[7:0] : tx_data_reg;
      TX_LOAD    <= wr_txd;
    end
  end

endmodule

// File: bench/uart_engine_model.sv
// Behavioural serial engine on the far side of the register block
`timescale 1ns/1ps
module uart_engine_model (
  // Clock and reset
  input  wire       MCLK,
  input  wire       RESET_N,
  // Commands from the register block and the bench
  input  wire       TX_LOAD,
  input  wire       rx_go,
  input  wire [9:0] rx_in,
  // Engine events
  output wire       TX_TAKEN,
  output wire       TX_END_EVT,
  output wire       TX_BUSY,
  output reg        RX_PUSH,
  output reg  [7:0] RX_BYTE,
  output reg        RX_FERR,
  output reg        RX_PERR,
  output wire       RX_BUSY
);
  reg [2:0] cnt_reg;
  assign TX_BUSY = cnt_reg != 3'h0;
  assign TX_TAKEN = cnt_reg == 3'h4;
  assign TX_END_EVT = cnt_reg == 3'h1;
  assign RX_BUSY = rx_go;
  always @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cnt_reg <= 3'h0;
      RX_PUSH <= 1'b0;
      {RX_FERR, RX_PERR, RX_BYTE} <= 10'h000;
    end else begin
      // Idle data inverts so a stale byte never looks valid
      {RX_FERR, RX_PERR, RX_BYTE} <= rx_go ? rx_in : ~{RX_FERR, RX_PERR, RX_BYTE};
      RX_PUSH <= rx_go;
      cnt_reg <= TX_LOAD ? 3'h5 : cnt_reg - {2'b00, TX_BUSY};
    end
  end
endmodule

// File: bench/uart_regs_chk.sv
// Assertion checker of the serial channel register port
`timescale 1ns/1ps
module uart_regs_chk (
  // Register port and engine events
  input wire        MCLK,
  input wire        RESET_N,
  input wire [15:0] ADDR,
  input wire [15:0] WDATA,
  input wire        WR,
  input wire        RD,
  input wire [15:0] RDATA,
  input wire        IRQ,
  input wire [7:0]  TX_DATA,
  input wire        TX_LOAD,
  input wire        TX_TAKEN,
  input wire        RX_PUSH
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESET_N);
  sequence rd_st; RD && ADDR == 16'h438C; endsequence
  sequence rd_rx; RD && ADDR == 16'h438A; endsequence
  sequence wr_st; WR && ADDR == 16'h438C; endsequence
  sequence wr_tx; WR && ADDR == 16'h4388; endsequence
  keep_sticky_a: assert property (rd_st ##1 (wr_st and (!WDATA[6] && !WDATA[3])) ##1 rd_st
    |=> ($past(RDATA, 2) & ~RDATA & 16'h0048) == 16'h0000) else $error("sticky flag lost");
  err_rdclr_a: assert property ((rd_rx and !RX_PUSH) ##1 rd_st |=> RDATA[5:4] == 2'b00)
    else $error("error flags kept");
  rx_pop_a: assert property (rd_rx ##1 rd_st |=> !RDATA[2])
    else $error("two bytes flag kept");
  tbe_clr_a: assert property ((wr_tx and !TX_TAKEN) ##1 rd_st |=> !RDATA[0])
    else $error("tx empty kept");
  tx_load_a: assert property (wr_tx |=> TX_LOAD && TX_DATA == $past(WDATA[7:0]))
    else $error("tx load wrong");
  irq_cause_a: assert property (rd_st and IRQ |=> RDATA[6:0] != 7'h00)
    else $error("irq without flag");
  irq_mask_a: assert property (WR && ADDR == 16'h438E && WDATA[6:0] == 7'h00 |=> !IRQ)
    else $error("irq not masked");
endmodule
bind uart_register_interface uart_regs_chk chk_i (.MCLK, .RESET_N, .ADDR, .WDATA, .WR, .RD,
  .RDATA, .IRQ, .TX_DATA, .TX_LOAD, .TX_TAKEN, .RX_PUSH);

// File: bench/tb_top.sv
// Self-checking bench of the serial channel register block
`timescale 1ns/1ps
module tb_top;
  reg         MCLK = 1'b0;
  reg         RESET_N = 1'b0;
  reg  [15:0] ADDR = 16'h0000;
  reg  [15:0] WDATA = 16'h0000;
  reg         WR = 1'b0;
  reg         RD = 1'b0;
  reg         rx_go = 1'b0;
  reg  [9:0]  rx_in = 10'h000;
  reg  [15:0] q;
  reg  [15:0] i;
  reg  [31:0] seed = 32'h0000_A164;
  reg  [7:0]  b0;
  reg  [7:0]  b1;
  integer     n_mismatch = 0;
  integer     samples_checked = 0;
  wire [15:0] RDATA;
  wire [7:0]  TX_DATA, RX_BYTE;
  wire        IRQ, TX_LOAD, TX_TAKEN, TX_END_EVT, TX_BUSY, RX_PUSH, RX_FERR, RX_PERR, RX_BUSY;
  always #10 MCLK = ~MCLK;
  uart_register_interface uart_register_interface_i (.MCLK, .RESET_N, .ADDR, .WDATA, .WR,
    .RD, .RDATA, .IRQ, .CLK_SRC(), .CLK_DIV(), .DBG_RUN(), .FRAME_MODE(), .BAUD_FINE(),
    .BAUD_COUNT(), .MOD_EN(), .SOFT_RST(), .TX_DATA, .TX_LOAD, .TX_TAKEN, .TX_END_EVT,
    .TX_BUSY, .RX_PUSH, .RX_BYTE, .RX_FERR, .RX_PERR, .RX_BUSY);
  uart_engine_model uart_engine_model_i (.MCLK, .RESET_N, .TX_LOAD, .rx_go, .rx_in,
    .TX_TAKEN, .TX_END_EVT, .TX_BUSY, .RX_PUSH, .RX_BYTE, .RX_FERR, .RX_PERR, .RX_BUSY);
  function [31:0] xs(input [31:0] s);
    xs = s ^ (s << 13);
    xs = xs ^ (xs >> 17);
    xs = xs ^ (xs << 5);
  endfunction
  function [15:0] msk(input [15:0] k);
    msk = k == 16'h0000 ? 16'h0133 : k == 16'h0001 ? 16'h077F : 16'h0FFF;
  endfunction
  // One bus cycle; q then holds the answer to the previous cycle's read
  task cyc(input w, input r, input [15:0] a, input [15:0] d);
    begin
      @(posedge MCLK);
      WR <= w;
      RD <= r;
      ADDR <= a;
      WDATA <= d;
      #1 q = RDATA;
    end
  endtask
  task chk(input [63:0] nm, input [15:0] seen, input [15:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("Error %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task rdc(input [63:0] nm, input [15:0] a, input [15:0] exp);
    begin
      cyc(1'b0, 1'b1, a, 16'h0000);
      cyc(1'b0, 1'b0, 16'h0000, 16'h0000);
      chk(nm, q, exp);
    end
  endtask
  task push(input [9:0] v);
    begin
      @(posedge MCLK);
      rx_go <= 1'b1;
      rx_in <= v;
      @(posedge MCLK);
      rx_go <= 1'b0;
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  initial begin
    repeat (8) @(posedge MCLK);
    RESET_N <= 1'b1;
    rdc("status", 16'h438C, 16'h0001);
    rdc("unmap", 16'h4390, 16'h0000);
    for (i = 16'h0000; i < 16'h0003; i = i + 16'h0001) begin
      seed = xs(seed);
      cyc(1'b1, 1'b0, 16'h4380 + {i[14:0], 1'b0}, seed[15:0]);
      rdc("config", 16'h4380 + {i[14:0], 1'b0}, seed[15:0] & msk(i));
    end
    cyc(1'b1, 1'b0, 16'h438E, 16'h0001);
    cyc(1'b0, 1'b0, 16'h0000, 16'h0000);
    chk("irq_on", {15'h0000, IRQ}, 16'h0001);
    cyc(1'b1, 1'b0, 16'h438E, 16'h007E);
    cyc(1'b0, 1'b0, 16'h0000, 16'h0000);
    chk("irq_off", {15'h0000, IRQ}, 16'h0000);
    $display("test regs done");
    seed = xs(seed);
    cyc(1'b1, 1'b0, 16'h4388, seed[15:0]);
    cyc(1'b0, 1'b1, 16'h438C, 16'h0000);
    chk("tx_data", {8'h00, TX_DATA}, {8'h00, seed[7:0]});
    // Engine starts one cycle after the load, so busy shows on the second read
    cyc(1'b0, 1'b1, 16'h438C, 16'h0000);
    chk("tx_clear", q, 16'h0000);
    cyc(1'b0, 1'b0, 16'h0000, 16'h0000);
    chk("tx_busy", q, 16'h0100);
    i = 16'h0000;
    // Bounded poll for the end of transmission
    while (q !== 16'h0041 && i < 16'h0014) begin
      cyc(1'b0, 1'b1, 16'h438C, 16'h0000);
      cyc(1'b0, 1'b0, 16'h0000, 16'h0000);
      i = i + 16'h0001;
    end
    chk("tx_end", q, 16'h0041);
    if (q !== 16'h0041) give_verdict;
    cyc(1'b0, 1'b1, 16'h438C, 16'h0000);
    cyc(1'b1, 1'b0, 16'h438C, 16'h0037);
    cyc(1'b0, 1'b1, 16'h438C, 16'h0000);
    cyc(1'b1, 1'b0, 16'h438C, 16'h0040);
    chk("wr_zero", q, 16'h0041);
    rdc("wr_one", 16'h438C, 16'h0001);
    $display("test tx done");
    seed = xs(seed);
    b0 = seed[7:0];
    b1 = seed[15:8];
    push({2'b11, b0});
    push({2'b00, b1});
    push({2'b00, seed[23:16]});
    rdc("rx_full", 16'h438C, 16'h003F);
    chk("irq_rx", {15'h0000, IRQ}, 16'h0001);
    cyc(1'b0, 1'b1, 16'h438A, 16'h0000);
    cyc(1'b0, 1'b1, 16'h438C, 16'h0000);
    chk("rx_b0", q, {8'h00, b0});
    cyc(1'b1, 1'b0, 16'h438C, 16'h0008);
    chk("rx_pop", q, 16'h000B);
    cyc(1'b0, 1'b1, 16'h438A, 16'h0000);
    cyc(1'b0, 1'b1, 16'h438C, 16'h0000);
    chk("rx_b1", q, {8'h00, b1});
    cyc(1'b1, 1'b0, 16'h438E, 16'h0000);
    chk("rx_empty", q, 16'h0001);
    cyc(1'b0, 1'b0, 16'h0000, 16'h0000);
    chk("irq_mask", {15'h0000, IRQ}, 16'h0000);
    $display("test rx done");
    give_verdict;
  end
endmodule
